// *** logic/adc_backend.sv ***
// Converter back end: register bank, overrange flag, calibration gate, test patterns.
// Assumes one 12-bit two's complement sample per clock from the pipeline corrector.
`timescale 1ns/1ns
`default_nettype none
`include "adc_backend_params.svh"

module adc_backend
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [11:0] sample,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        sdioIn,
  output logic             sdioOut,
  output logic             sdioOe,
  output logic             overrangeFlag,
  output logic             calCoeffUpdate,
  output logic [15:0]      calEstimate,
  output logic [11:0]      framerData
);
  import adc_backend_pkg::*;

  regAccess_type access;
  logic          accessStrobe;
  logic [7:0]    readData;
  logic [7:0]    regBank [0:`BANK_LAST];
  logic [15:0]   upperThreshold;
  logic [15:0]   lowerThreshold;
  logic [15:0]   dwellTime;
  logic [15:0]   calThreshold;
  logic [11:0]   capturedSample;
  logic [15:0]   dwellCount;
  logic [25:0]   calSum;
  logic [10:0]   calCount;
  logic [7:0]    updateCount;
  logic          toggle;
  logic [11:0]   ramp;
  logic [22:0]   pnState;
  logic [1:0]    userIndex;

  serial_control_port controlPort
  (
    .clock        (clock),
    .rst          (rst),
    .sclk         (sclk),
    .csN          (csN),
    .sdioIn       (sdioIn),
    .sdioOut      (sdioOut),
    .sdioOe       (sdioOe),
    .access       (access),
    .accessStrobe (accessStrobe),
    .readData     (readData)
  );

  // Magnitude scaled so that the negative full-scale code 0x800 reads 0x4000, shared by both detectors.
  function automatic logic [15:0] scaledMagnitude(input logic [11:0] value);
    logic [11:0] mag;
    mag = value[11] ? 12'(~value + 12'h001) : value;
    return {1'b0, mag, 3'b000};
  endfunction : scaledMagnitude

  // Bytes that are staged in the bank; a high threshold byte also loads the full value.
  function automatic logic isMapped(input logic [6:0] addr);
    return addr == `OFS_TEST_MODE || addr == `OFS_FORMAT || addr == `OFS_CAL_CTRL
        || (addr >= `OFS_USER_FIRST && addr <= `OFS_USER_LAST)
        || (addr >= `OFS_LOWER_LO && addr <= `OFS_DWELL_HI)
        || addr == `OFS_CALTH_LO || addr == `OFS_CALTH_HI;
  endfunction : isMapped

  wire         writeHit   = accessStrobe && access.write && isMapped(access.addr);
  wire [3:0]   testMode   = regBank[`OFS_TEST_MODE][3:0];
  wire         offsetBin  = regBank[`OFS_FORMAT][`BIT_OFFSET_BINARY];
  wire         gateEnable = regBank[`OFS_CAL_CTRL][`BIT_GATE_ENABLE];
  wire         calRun     = regBank[`OFS_CAL_CTRL][`BIT_CAL_RUN];
  wire [15:0]  magnitude  = scaledMagnitude(capturedSample);
  wire [15:0]  average    = 16'(({10'h000, magnitude} + calSum) >> `CAL_LOG2_COUNT);
  wire         calDone    = calRun && calCount == `CAL_SAMPLE_COUNT - 11'h001;
  wire [15:0]  newCalTh   = {access.data, regBank[`OFS_CALTH_LO]};
  wire [6:0]   userLo     = `OFS_USER_FIRST + {4'h0, userIndex, 1'b0};
  wire [11:0]  userWord   = {regBank[userLo + 7'h01][3:0], regBank[userLo]};
  wire         dwellDone  = dwellCount > dwellTime;

  // Unmapped or write-only addresses read as zero; status shows live block state.
  wire [7:0] statusByte = {updateCount[6:0], overrangeFlag};
  assign readData = (access.addr == `OFS_STATUS) ? statusByte
                  : (access.addr <= `BANK_LAST && isMapped(access.addr)) ? regBank[access.addr]
                  : 8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i <= `BANK_LAST; i++)
        regBank[i] <= 8'h00;
      regBank[`OFS_CAL_CTRL] <= `RST_CAL_CTRL; // RULE7
      regBank[`OFS_LOWER_LO] <= 8'(`RST_LOWER & 16'h00ff);
      regBank[`OFS_UPPER_LO] <= 8'(`RST_UPPER & 16'h00ff);
      regBank[`OFS_DWELL_LO] <= 8'(`RST_DWELL & 16'h00ff);
    end
    else if (writeHit)
      regBank[access.addr] <= access.data;
  end

  // Threshold values change only when the high byte lands, so no torn value is ever used.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      lowerThreshold <= `RST_LOWER;
      upperThreshold <= `RST_UPPER;
      dwellTime      <= `RST_DWELL;
      calThreshold   <= `RST_CAL_THRESHOLD;
    end
    else if (writeHit)
    begin
      if (access.addr == `OFS_LOWER_HI)
        lowerThreshold <= {access.data, regBank[`OFS_LOWER_LO]}; // RULE8
      if (access.addr == `OFS_UPPER_HI)
        upperThreshold <= {access.data, regBank[`OFS_UPPER_LO]}; // RULE8
      if (access.addr == `OFS_DWELL_HI)
        dwellTime <= {access.data, regBank[`OFS_DWELL_LO]};
      if (access.addr == `OFS_CALTH_HI)
        calThreshold <= (newCalTh > `CAL_THRESHOLD_MAX) ? `CAL_THRESHOLD_MAX : newCalTh; // RULE9
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      capturedSample <= 12'h000;
    else
      capturedSample <= sample; // RULE1
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      overrangeFlag <= 1'b0;
      dwellCount    <= 16'h0000;
    end
    else if (magnitude > upperThreshold)
    begin
      overrangeFlag <= 1'b1; // RULE2
      dwellCount    <= 16'h0000;
    end
    else if (magnitude >= lowerThreshold)
      dwellCount <= 16'h0000; // RULE4
    else if (overrangeFlag && dwellDone)
    begin
      overrangeFlag <= 1'b0; // RULE3
      dwellCount    <= 16'h0000;
    end
    else if (overrangeFlag)
      dwellCount <= dwellCount + 16'h0001; // RULE3
  end

  always_ff @(posedge clock)
  begin
    calCoeffUpdate <= 1'b0;
    if (rst || !calRun)
    begin
      calSum   <= 26'h0000000;
      calCount <= 11'h000;
      if (rst)
      begin
        calEstimate <= 16'h0000;
        updateCount <= 8'h00;
      end
    end
    else if (calDone)
    begin
      calEstimate <= average; // RULE5
      calSum      <= 26'h0000000;
      calCount    <= 11'h000;
      if (!gateEnable || average > calThreshold)
      begin
        calCoeffUpdate <= 1'b1; // RULE6
        updateCount    <= updateCount + 8'h01;
      end
    end
    else
    begin
      calSum   <= calSum + {10'h000, magnitude}; // RULE5
      calCount <= calCount + 11'h001;
    end
  end

  // PN23 generator: long enough that the receiver sees no repeat inside a capture.
  always_ff @(posedge clock)
  begin
    if (rst || testMode != `MODE_PN_LONG)
      pnState <= `PN_SEED;
    else
      pnState <= {pnState[21:0], pnState[22] ^ pnState[17]}; // RULE14
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      toggle    <= 1'b0;
      ramp      <= 12'h000;
      userIndex <= 2'h0;
    end
    else
    begin
      toggle    <= ~toggle;
      ramp      <= ramp + 12'h001; // RULE12
      userIndex <= (testMode == `MODE_USER) ? userIndex + 2'h1 : 2'h0; // RULE13
    end
  end

  logic [11:0] patternWord;
  logic        formatted;
  always_comb
  begin
    formatted = 1'b1;
    case (testMode)
      `MODE_OFF:         patternWord = capturedSample; // RULE10
      `MODE_MIDSCALE:    patternWord = `WORD_MIDSCALE; // RULE11
      `MODE_POS_FULL:    patternWord = `WORD_POS_FULL; // RULE11
      `MODE_NEG_FULL:    patternWord = `WORD_NEG_FULL; // RULE11
      `MODE_PN_LONG:     patternWord = pnState[11:0]; // RULE14
      `MODE_USER:        patternWord = userWord; // RULE13
      `MODE_CHECKER:
      begin
        patternWord = toggle ? `WORD_CHECKER_B : `WORD_CHECKER_A; // RULE12
        formatted   = 1'b0;
      end
      `MODE_WORD_TOGGLE:
      begin
        patternWord = toggle ? `WORD_MIDSCALE : `WORD_ONES; // RULE12
        formatted   = 1'b0;
      end
      `MODE_RAMP:
      begin
        patternWord = ramp; // RULE12
        formatted   = 1'b0;
      end
      default:           patternWord = capturedSample;
    endcase
  end

  // Offset binary flips only the sign bit, so the raw patterns stay exactly as listed.
  always_ff @(posedge clock)
  begin
    if (rst)
      framerData <= 12'h000;
    else
      framerData <= {patternWord[11] ^ (formatted & offsetBin), patternWord[10:0]}; // RULE15
  end

endmodule : adc_backend
`default_nettype wire

// *** logic/adc_backend_params.svh ***
// Offsets, field positions, reset values and counts for the converter back end.
// Assumes a 7-bit register address carried by the serial control port.
// Overview of operation
// (RULE1) Each converter sample is captured on the rising clock edge while later stages keep working.
// (RULE2) The overrange flag rises as soon as a sample magnitude exceeds the upper threshold.
// (RULE3) The flag falls only after the magnitude stays below the lower threshold longer than the dwell.
// (RULE4) The dwell timer restarts whenever a magnitude climbs back to the lower threshold or above.
// (RULE5) During calibration every sample magnitude is summed over a fixed count into an average.
// (RULE6) At the end of each count the average is compared and coefficients update only if greater.
// (RULE7) Threshold gating of calibration updates is on after reset.
// (RULE8) Each 16-bit threshold is written one byte per transfer and assembled by the device.
// (RULE9) The calibration threshold spans 0 to 0x4000, where 0x4000 is full-scale average magnitude.
// (RULE10) A 4-bit test-mode field at output_test_pattern_select selects the pattern, 0000 passing normal samples.
// (RULE11) Codes 0001, 0010, 0011 give midscale, positive full scale and negative full scale.
// (RULE12) Codes 0100, 0111, 1111 give checkerboard, ones/zeros toggle and a ramp, never reformatted.
// (RULE13) Code 1000 outputs the user words held at 0x019 through 0x020, reformatted.
// (RULE14) Code 0101 outputs a long pseudo-random sequence; PN, constant and user words are reformatted.
// (RULE15) A nonzero test mode replaces the samples at the framing input without lane changes; codes 0110 and 1001 to 1110 pass the captured samples.
`ifndef ADC_BACKEND_PARAMS_SVH
`define ADC_BACKEND_PARAMS_SVH

`define OFS_FORMAT        7'h14
`define OFS_TEST_MODE     7'h0d
`define OFS_USER_FIRST    7'h19
`define OFS_USER_LAST     7'h20
`define OFS_LOWER_LO      7'h45
`define OFS_LOWER_HI      7'h46
`define OFS_UPPER_LO      7'h47
`define OFS_UPPER_HI      7'h48
`define OFS_DWELL_LO      7'h49
`define OFS_DWELL_HI      7'h4a
`define OFS_CALTH_LO      7'h50
`define OFS_CALTH_HI      7'h51
`define OFS_CAL_CTRL      7'h52
`define OFS_STATUS        7'h53
`define BANK_LAST         7'h53

`define BIT_OFFSET_BINARY 0
`define BIT_GATE_ENABLE   0
`define BIT_CAL_RUN       1
`define RST_CAL_CTRL      8'h03
`define RST_CAL_THRESHOLD 16'h0000
`define RST_UPPER         16'h4000
`define RST_LOWER         16'h2000
`define RST_DWELL         16'h0010
`define CAL_THRESHOLD_MAX 16'h4000

`define CAL_LOG2_COUNT    10
`define CAL_SAMPLE_COUNT  11'h400
`define SPI_FRAME_BITS    5'h18
`define SPI_INSTR_BITS    5'h10

`define MODE_OFF          4'h0
`define MODE_MIDSCALE     4'h1
`define MODE_POS_FULL     4'h2
`define MODE_NEG_FULL     4'h3
`define MODE_CHECKER      4'h4
`define MODE_PN_LONG      4'h5
`define MODE_WORD_TOGGLE  4'h7
`define MODE_USER         4'h8
`define MODE_RAMP         4'hf

`define WORD_MIDSCALE     12'h000
`define WORD_POS_FULL     12'h7ff
`define WORD_NEG_FULL     12'h800
`define WORD_CHECKER_A    12'haaa
`define WORD_CHECKER_B    12'h555
`define WORD_ONES         12'hfff
`define PN_SEED           23'h7fffff

`endif

// *** logic/adc_backend_pkg.sv ***
// Types shared by the serial control port and the converter back end.
// Assumes the constants header is included by the files that need numbers.
`default_nettype none
package adc_backend_pkg;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
    logic [7:0] data;
  } regAccess_type;

  typedef enum logic [1:0] {IDLE, INSTRUCTION, DATA} spiState_type;

endpackage : adc_backend_pkg
`default_nettype wire

// *** logic/serial_control_port.sv ***
// Serial control port: 16-bit instruction (read flag, address) then one data byte.
// Assumes sclk, csN and sdio are synchronous to clock and much slower than it.
`timescale 1ns/1ns
`default_nettype none
`include "adc_backend_params.svh"

module serial_control_port
(
  input  wire logic                          clock,
  input  wire logic                          rst,
  input  wire logic                          sclk,
  input  wire logic                          csN,
  input  wire logic                          sdioIn,
  output logic                               sdioOut,
  output logic                               sdioOe,
  output adc_backend_pkg::regAccess_type     access,
  output logic                               accessStrobe,
  input  wire logic [7:0]                    readData
);
  import adc_backend_pkg::*;

  spiState_type state;
  logic         sclkLast;
  logic [4:0]   bitCount;
  logic [15:0]  shiftIn;
  logic [7:0]   shiftOut;
  logic         readCycle;
  logic [6:0]   addr;

  wire sclkRise = sclk & ~sclkLast;
  wire sclkFall = ~sclk & sclkLast;
  wire [15:0] nextShift = {shiftIn[14:0], sdioIn};
  wire [4:0]  nextCount = bitCount + 5'h01;

  // Only one byte per frame; extra clocks before deselect are ignored.
  always_ff @(posedge clock)
  begin
    sclkLast     <= sclk;
    accessStrobe <= 1'b0;
    if (rst || csN)
    begin
      state    <= IDLE;
      bitCount <= 5'h00;
      sdioOe   <= 1'b0;
      sdioOut  <= 1'b0;
      if (rst)
      begin
        shiftIn   <= 16'h0000;
        shiftOut  <= 8'h00;
        readCycle <= 1'b0;
        addr      <= 7'h00;
        access    <= '0;
      end
    end
    else
    begin
      if (state == IDLE)
        state <= INSTRUCTION;
      if (sclkRise && bitCount < `SPI_FRAME_BITS)
      begin
        shiftIn  <= nextShift;
        bitCount <= nextCount;
        if (nextCount == `SPI_INSTR_BITS)
        begin
          state     <= DATA;
          readCycle <= nextShift[15];
          addr      <= nextShift[6:0];
        end
        if (nextCount == `SPI_FRAME_BITS && !readCycle)
        begin
          access       <= '{write: 1'b1, addr: addr, data: nextShift[7:0]}; // RULE8
          accessStrobe <= 1'b1;
        end
      end
      if (state == DATA && readCycle && sclkFall)
      begin
        if (bitCount == `SPI_INSTR_BITS && !sdioOe)
        begin
          sdioOut  <= readData[7];
          shiftOut <= {readData[6:0], 1'b0};
          sdioOe   <= 1'b1;
        end
        else if (bitCount < `SPI_FRAME_BITS)
        begin
          sdioOut  <= shiftOut[7];
          shiftOut <= {shiftOut[6:0], 1'b0};
        end
        else
          sdioOe <= 1'b0;
      end
      if (state == DATA && readCycle)
        access <= '{write: 1'b0, addr: addr, data: 8'h00};
    end
  end

endmodule : serial_control_port
`default_nettype wire

// *** verification/adc_backend_chk.sv ***
// Port checker for the converter back end, bound to adc_backend.
// Assumes the bench programs these thresholds before it drives large samples.
`timescale 1ns/1ns
`default_nettype none
module adc_backend_chk
#(
  parameter logic [15:0] UPPER = 16'h3000,
  parameter logic [15:0] LOWER = 16'h1000,
  parameter logic [15:0] DWELL = 16'h0004,
  parameter logic [15:0] CALTH = 16'h0400
)
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [11:0] sample,
  input wire logic        sclk,
  input wire logic        csN,
  input wire logic        sdioIn,
  input wire logic        sdioOut,
  input wire logic        sdioOe,
  input wire logic        overrangeFlag,
  input wire logic        calCoeffUpdate,
  input wire logic [15:0] calEstimate,
  input wire logic [11:0] framerData
);
  logic [15:0] lowRun;
  logic [10:0] sinceUpd;
  wire logic [15:0] mag = {1'b0, (sample[11] ? 12'h000 - sample : sample), 3'b000};
  wire logic        low = mag < LOWER;
  wire logic        big = mag > UPPER;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // The gate check holds only while the gate bit keeps its reset value.
  always_ff @(posedge clock)
  begin
    lowRun   <= rst ? 16'h0000 : (low ? lowRun + 16'h0001 : 16'h0000);
    sinceUpd <= (rst || calCoeffUpdate) ? 11'h000 : sinceUpd + {10'h000, ~&sinceUpd};
  end
  property p_set; big |-> ##2 overrangeFlag; endproperty
  a_set: assert property (p_set) else $error("flag missed a large sample");
  property p_cause; $rose(overrangeFlag) |-> $past(big, 2); endproperty
  a_cause: assert property (p_cause) else $error("flag rose without cause");
  property p_clr_min; $fell(overrangeFlag) |-> $past(lowRun, 2) >= DWELL + 16'h0001; endproperty
  a_clr_min: assert property (p_clr_min) else $error("flag cleared early");
  property p_clr_due;
    overrangeFlag && lowRun == DWELL + 16'h0002 |-> ##[1:4] !overrangeFlag;
  endproperty
  a_clr_due: assert property (p_clr_due) else $error("flag cleared late");
  property p_pulse; calCoeffUpdate |=> !calCoeffUpdate; endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse too long");
  property p_count; calCoeffUpdate |-> sinceUpd >= 11'h3ff; endproperty
  a_count: assert property (p_count) else $error("update before full count");
  property p_gate; calCoeffUpdate |-> ##[0:1] calEstimate > CALTH; endproperty
  a_gate: assert property (p_gate) else $error("update below threshold");
  property p_oe; csN && $past(csN) |-> !sdioOe; endproperty
  a_oe: assert property (p_oe) else $error("data driven while deselected");
endmodule : adc_backend_chk
bind adc_backend adc_backend_chk u_chk (.clock(clock), .rst(rst), .sample(sample),
  .sclk(sclk), .csN(csN), .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe),
  .overrangeFlag(overrangeFlag), .calCoeffUpdate(calCoeffUpdate),
  .calEstimate(calEstimate), .framerData(framerData));
`default_nettype wire

// *** verification/adc_spi_host.sv ***
// Host model for the serial control port: one byte per frame, MSB first.
// Assumes clock is the device clock; serial edges last two clocks each.
`timescale 1ns/1ns
`default_nettype none
module adc_spi_host
(
  input  wire logic clock,
  input  wire logic sdioOut,
  input  wire logic sdioOe,
  output logic      sclk,
  output logic      csN,
  output logic      sdioIn
);
  logic drv;
  logic hostOe;
  // A released line shows the inverse of the last bit, so a late read sees garbage.
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? drv : ~drv);
  initial
  begin
    sclk   = 1'b0;
    csN    = 1'b1;
    drv    = 1'b0;
    hostOe = 1'b1;
  end
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [23:0] w;
    w = {rw, 8'h00, a, d};
    q = 8'h00;
    @(negedge clock) csN <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      @(negedge clock);
      sclk   <= 1'b0;
      drv    <= w[i];
      hostOe <= !(rw && i < 8);
      repeat (2) @(negedge clock);
      sclk <= 1'b1;
      if (i < 8) q[i[2:0]] = sdioIn;
      @(negedge clock);
    end
    @(negedge clock);
    sclk   <= 1'b0;
    csN    <= 1'b1;
    hostOe <= 1'b1;
    repeat (4) @(negedge clock);
  endtask : xfer
endmodule : adc_spi_host
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for adc_backend: registers, overrange flag, calibration, patterns.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock, rst, sclk, csN, sdioIn, sdioOut, sdioOe, overrangeFlag, calCoeffUpdate;
  logic [11:0] sample, framerData, a;
  logic [15:0] calEstimate;
  logic [7:0]  rd;
  int          bad_count, n_checks, k;
  logic [3:0]  pm [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
  logic [11:0] pw [4] = '{12'h123, 12'h000, 12'h7ff, 12'h800};
  logic [11:0] uw [4] = '{12'ha19, 12'hc1b, 12'he1d, 12'h01f};
  adc_backend u_dut (.clock(clock), .rst(rst), .sample(sample), .sclk(sclk), .csN(csN),
    .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOe(sdioOe), .overrangeFlag(overrangeFlag),
    .calCoeffUpdate(calCoeffUpdate), .calEstimate(calEstimate), .framerData(framerData));
  adc_spi_host u_host (.clock(clock), .sdioOut(sdioOut), .sdioOe(sdioOe), .sclk(sclk),
    .csN(csN), .sdioIn(sdioIn));
  always #4 clock = ~clock;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  task tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task wr(input logic [6:0] ad, input logic [7:0] d);
    u_host.xfer(1'b0, ad, d, rd);
  endtask : wr
  task rdchk(input logic [6:0] ad, input logic [7:0] e);
    u_host.xfer(1'b1, ad, 8'h00, rd);
    chk({8'h00, rd}, {8'h00, e});
  endtask : rdchk
  // Low byte first: the live value only changes when the high byte lands.
  task wr16(input logic [6:0] ad, input logic [15:0] v);
    wr(ad, v[7:0]);
    wr(ad + 7'h01, v[15:8]);
  endtask : wr16
  task waitv(input logic which, input logic v, input int lim);
    int n;
    n = 0;
    while (((which ? calCoeffUpdate : overrangeFlag) !== v) && n < lim)
    begin
      tick(1);
      n++;
    end
    if (n >= lim)
    begin
      chk(16'h0000, 16'h0001);
      finish_test();
    end
  endtask : waitv
  task pat(input logic [3:0] m, input logic [11:0] e);
    wr(7'h0d, {4'h0, m});
    tick(3);
    chk({4'h0, framerData}, {4'h0, e});
  endtask : pat
  task alt(input logic [3:0] m, input logic [11:0] w1, input logic [11:0] w2);
    wr(7'h0d, {4'h0, m});
    tick(3);
    a = framerData;
    tick(1);
    chk({4'h0, (a == w1) ? framerData : a}, {4'h0, w2});
    chk({4'h0, a ^ framerData}, {4'h0, w1 ^ w2});
  endtask : alt
  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    sample = 12'h000;
    bad_count = 0;
    n_checks = 0;
    tick(16);
    rst = 1'b0;
    tick(2);
    chk({4'h0, framerData}, 16'h0000);
    rdchk(7'h0d, 8'h00);
    rdchk(7'h52, 8'h03);
    rdchk(7'h7f, 8'h00);
    wr16(7'h50, 16'h0400);
    wr16(7'h47, 16'h3000);
    wr16(7'h45, 16'h1000);
    wr16(7'h49, 16'h0004);
    rdchk(7'h50, 8'h00);
    rdchk(7'h51, 8'h04);
    $display("Test registers done");
    sample = 12'h700;
    tick(1);
    sample = 12'h000;
    waitv(1'b0, 1'b1, 5);
    tick(3);
    sample = 12'h300;
    tick(1);
    sample = 12'h000;
    tick(6);
    chk({15'h0, overrangeFlag}, 16'h0001);
    waitv(1'b0, 1'b0, 12);
    sample = 12'h800;
    tick(1);
    sample = 12'h000;
    waitv(1'b0, 1'b1, 5);
    waitv(1'b0, 1'b0, 20);
    $display("Test overrange done");
    sample = 12'h123;
    for (int i = 0; i < 4; i++) pat(pm[i], pw[i]);
    alt(4'h4, 12'haaa, 12'h555);
    alt(4'h7, 12'hfff, 12'h000);
    wr(7'h0d, 8'h0f);
    tick(3);
    a = framerData;
    tick(1);
    chk({4'h0, framerData - a}, 16'h0001);
    wr(7'h0d, 8'h05);
    tick(3);
    a = framerData;
    tick(1);
    chk({15'h0, a !== framerData}, 16'h0001);
    chk({5'h00, framerData[11:1]}, {5'h00, a[10:0]});
    wr(7'h14, 8'h01);
    pat(4'h1, 12'h800);
    pat(4'h0, 12'h923);
    alt(4'h4, 12'haaa, 12'h555);
    wr(7'h14, 8'h00);
    for (int j = 25; j <= 32; j++) wr(7'(j), 8'(j));
    wr(7'h0d, 8'h08);
    tick(3);
    a = framerData;
    for (k = 0; k < 4 && uw[k] !== a; k++);
    chk({4'h0, a}, {4'h0, uw[k % 4]});
    repeat (4)
    begin
      tick(1);
      k++;
      chk({4'h0, framerData}, {4'h0, uw[k % 4]});
    end
    pat(4'h0, 12'h123);
    $display("Test patterns done");
    sample = 12'h100;
    waitv(1'b1, 1'b1, 2100);
    tick(2);
    waitv(1'b1, 1'b1, 1100);
    tick(2);
    chk(calEstimate, 16'h0800);
    sample = 12'h040;
    tick(1100);
    k = 0;
    repeat (1100)
    begin
      tick(1);
      if (calCoeffUpdate === 1'b1) k++;
    end
    chk(k[15:0], 16'h0000);
    chk(calEstimate, 16'h0200);
    $display("Test calibration done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
